// *** common/fsdo_pkg.sv ***
// shared constants and types of the fail-safe discrete output port
// assumes a single 20 MHz clock and a plain strobe register port
package fsdo_pkg;

    // port geometry
    localparam int unsigned NUM_POINTS  = 4;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_OUT_IMAGE   = 8'h00;
    localparam logic [7:0] OFS_OUT_POINT   = 8'h04;
    localparam logic [7:0] OFS_PAT_STAGE   = 8'h08;
    localparam logic [7:0] OFS_PAT_POINT   = 8'h0c;
    localparam logic [7:0] OFS_KIND_STAGE  = 8'h10;
    localparam logic [7:0] OFS_DELAY_STAGE = 8'h14;
    localparam logic [7:0] OFS_COMMIT      = 8'h18;
    localparam logic [7:0] OFS_STATUS      = 8'h1c;

    // single-point write layout: point number and level
    localparam int unsigned PT_SEL_LSB = 0;
    localparam int unsigned PT_LVL_BIT = 8;

    // status word layout
    localparam int unsigned ST_SAFE_BIT  = 0;
    localparam int unsigned ST_LOST_BIT  = 1;
    localparam int unsigned ST_KIND_LSB  = 8;
    localparam int unsigned ST_DELAY_LSB = 16;
    localparam int unsigned ST_PAT_LSB   = 24;

    // fail-safe kind encodings
    localparam logic [7:0] KIND_ALL_OFF = 8'h01;
    localparam logic [7:0] KIND_PATTERN = 8'h02;
    localparam logic [7:0] KIND_HOLD    = 8'h03;

    // values after reset
    localparam logic [7:0] RST_KIND    = 8'h01;
    localparam logic [7:0] RST_DELAY   = 8'h00;
    localparam logic [3:0] RST_PATTERN = 4'h0;
    localparam logic [3:0] RST_IMAGE   = 4'h0;

    // timing: one delay unit is a tenth of a second
    localparam longint unsigned CLK_PERIOD_NS = 50;
    localparam longint unsigned TENTH_NS      = 100_000_000;
    localparam int unsigned     TENTH_CYCLES  = int'(TENTH_NS / CLK_PERIOD_NS);
    localparam int unsigned     TENTH_CNT_W   = 21;
    // host silence that counts as loss of communication, in tenths
    localparam logic [7:0]      WDOG_TENTHS   = 8'h05;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } fsdo_req_t;

    // active fail-safe configuration
    typedef struct packed {
        logic [7:0] kind;
        logic [7:0] delay;
        logic [3:0] pattern;
    } fsdo_cfg_t;

    // link supervision states, gray along normal -> lost -> safe
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_LOST   = 2'b01,
        ST_SAFE   = 2'b11
    } fsdo_state_t;

endpackage

// *** hdl/fsdo_tick_div.sv ***
// tenth-second enable divider, restartable
// assumes clr is from logic on the same clock
`timescale 1ns/1ps
module fsdo_tick_div #(
    parameter int unsigned CYCLES = 2_000_000,
    parameter int unsigned CNT_W  = 21
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic clr,
    output logic      tick
);
    logic [CNT_W-1:0] cnt_reg;
    wire              wrap = (cnt_reg == CNT_W'(CYCLES - 1));

    // one-cycle pulse every CYCLES clocks, phase restarted by clr
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
        end else if (clr || wrap) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick = wrap && !clr;
endmodule // fsdo_tick_div

// *** hdl/fsdo_tenth_timer.sv ***
// saturating counter of tenth ticks compared to a limit
// assumes tick and clr come from the same clock domain
`timescale 1ns/1ps
module fsdo_tenth_timer (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       clr,
    input  wire logic       tick,
    input  wire logic [7:0] limit,
    output logic            done
);
    logic [7:0] cnt_reg;

    // count ticks while not cleared, stop at the top
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
        end else if (clr) begin
            cnt_reg <= '0;
        end else if (tick && cnt_reg != 8'hff) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // limit zero is reached at once
    assign done = (cnt_reg >= limit);
endmodule // fsdo_tenth_timer

// *** hdl/fsdo_port.sv ***
// four-point discrete output port with host watchdog and fail-safe
// assumes a plain strobe register port from logic on clk; host traffic
// on that port is the only sign that the host is alive
`timescale 1ns/1ps

module fsdo_port #(
    parameter int unsigned TENTH_CYCLES = fsdo_pkg::TENTH_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire fsdo_pkg::fsdo_req_t         host_req,
    output logic [fsdo_pkg::DATA_W-1:0]      rd_data,
    output logic [fsdo_pkg::NUM_POINTS-1:0]  point_out,
    output logic                             failsafe_active,
    output logic                             comm_lost
);
    import fsdo_pkg::*;

    // register state
    logic [3:0]              image_reg;
    logic [3:0]              stg_pattern_reg;
    logic [7:0]              stg_kind_reg;
    logic [7:0]              stg_delay_reg;
    logic                    commit_reg;
    fsdo_cfg_t               act_cfg_reg;
    fsdo_state_t             state_reg;
    fsdo_state_t             state_next;
    logic [3:0]              point_out_reg;
    logic [3:0]              point_out_next;
    logic                    comm_lost_reg;
    logic                    failsafe_reg;
    logic [DATA_W-1:0]       rd_data_reg;

    // address decode
    wire       traffic     = host_req.wr || host_req.rd;
    wire       wr_image    = host_req.wr && host_req.addr == OFS_OUT_IMAGE;
    wire       wr_out_pt   = host_req.wr && host_req.addr == OFS_OUT_POINT;
    wire       wr_pat      = host_req.wr && host_req.addr == OFS_PAT_STAGE;
    wire       wr_pat_pt   = host_req.wr && host_req.addr == OFS_PAT_POINT;
    wire       wr_kind     = host_req.wr && host_req.addr == OFS_KIND_STAGE;
    wire       wr_delay    = host_req.wr && host_req.addr == OFS_DELAY_STAGE;
    wire       wr_commit   = host_req.wr && host_req.addr == OFS_COMMIT && host_req.wdata[0];
    wire [1:0] pt_sel      = host_req.wdata[PT_SEL_LSB +: 2];
    wire       pt_lvl      = host_req.wdata[PT_LVL_BIT];
    wire [3:0] pt_mask     = 4'h1 << pt_sel;

    // next values of the image and staged pattern
    wire [3:0] image_wr_val = wr_image ? host_req.wdata[3:0]
                            : (image_reg & ~pt_mask) | (pt_lvl ? pt_mask : 4'h0);
    wire [3:0] pat_wr_val   = wr_pat ? host_req.wdata[3:0]
                            : (stg_pattern_reg & ~pt_mask) | (pt_lvl ? pt_mask : 4'h0);

    // output image, written whole or one point at a time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            image_reg <= RST_IMAGE;
        end else if (wr_image || wr_out_pt) begin
            image_reg <= image_wr_val;
        end
    end

    // staged fail-safe settings, no effect until committed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stg_pattern_reg <= RST_PATTERN;
            stg_kind_reg    <= RST_KIND;
            stg_delay_reg   <= RST_DELAY;
        end else begin
            if (wr_pat || wr_pat_pt) begin
                stg_pattern_reg <= pat_wr_val;
            end
            if (wr_kind) begin
                stg_kind_reg <= host_req.wdata[7:0];
            end
            if (wr_delay) begin
                stg_delay_reg <= host_req.wdata[7:0];
            end
        end
    end

    // commit strobe: set by a write, cleared by the transfer it causes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            commit_reg <= 1'b0;
        end else if (wr_commit) begin
            commit_reg <= 1'b1; // a new commit wins over the clear
        end else if (commit_reg) begin
            commit_reg <= 1'b0;
        end
    end

    // active configuration taken only from the staged copy on commit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            act_cfg_reg <= '{kind: RST_KIND, delay: RST_DELAY, pattern: RST_PATTERN};
        end else if (commit_reg) begin
            act_cfg_reg <= '{kind: stg_kind_reg, delay: stg_delay_reg, pattern: stg_pattern_reg};
        end
    end

    // tenth-second timebase, phase restarted by every host access
    logic tenth_tick;
    fsdo_tick_div #(
        .CYCLES (TENTH_CYCLES),
        .CNT_W  (TENTH_CNT_W)
    ) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .clr  (traffic),
        .tick (tenth_tick)
    );

    // host silence watchdog
    logic wdog_done;
    fsdo_tenth_timer u_wdog (
        .clk   (clk),
        .rstn  (rstn),
        .clr   (traffic),
        .tick  (tenth_tick),
        .limit (WDOG_TENTHS),
        .done  (wdog_done)
    );

    // fail-safe entry delay, counts only while waiting after loss
    logic dly_done;
    fsdo_tenth_timer u_delay (
        .clk   (clk),
        .rstn  (rstn),
        .clr   (state_reg != ST_LOST),
        .tick  (tenth_tick),
        .limit (act_cfg_reg.delay),
        .done  (dly_done)
    );

    // loss is seen only while no access is under way
    wire lost_live = wdog_done && !traffic;

    // supervision state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_NORMAL: begin
                if (lost_live) begin
                    state_next = (act_cfg_reg.delay == 8'h00) ? ST_SAFE : ST_LOST;
                end
            end
            ST_LOST: begin
                if (traffic) begin
                    state_next = ST_NORMAL;
                end else if (dly_done) begin
                    state_next = ST_SAFE;
                end
            end
            ST_SAFE: begin
                if (traffic) begin
                    state_next = ST_NORMAL;
                end
            end
            default: begin
                state_next = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // output selection: fail-safe drive when the next state is safe, image otherwise
    wire       fs_live  = (state_next == ST_SAFE);
    wire       kind_pat = (act_cfg_reg.kind == KIND_PATTERN);
    wire       kind_hld = (act_cfg_reg.kind == KIND_HOLD);
    wire [3:0] fs_drive = kind_pat ? act_cfg_reg.pattern
                        : kind_hld ? point_out_reg
                        : 4'h0;                           // kind 1 and unknown kinds: all off
    assign point_out_next = fs_live ? fs_drive : image_reg;

    // registered outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            point_out_reg <= RST_IMAGE;
            comm_lost_reg <= 1'b0;
            failsafe_reg  <= 1'b0;
        end else begin
            point_out_reg <= point_out_next;
            comm_lost_reg <= lost_live;
            failsafe_reg  <= fs_live;
        end
    end

    // read mux; unused upper bits are zero
    wire [DATA_W-1:0] status_word = {4'h0, act_cfg_reg.pattern, act_cfg_reg.delay, act_cfg_reg.kind,
                                     6'h00, comm_lost_reg, (state_reg == ST_SAFE)};
    wire [DATA_W-1:0] rd_mux =
        (host_req.addr == OFS_OUT_IMAGE)   ? {28'h0000000, image_reg} :
        (host_req.addr == OFS_PAT_STAGE)   ? {28'h0000000, stg_pattern_reg} :
        (host_req.addr == OFS_KIND_STAGE)  ? {24'h000000, stg_kind_reg} :
        (host_req.addr == OFS_DELAY_STAGE) ? {24'h000000, stg_delay_reg} :
        (host_req.addr == OFS_COMMIT)      ? {31'h00000000, commit_reg} :
        (host_req.addr == OFS_STATUS)      ? status_word :
        32'h00000000;

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= host_req.rd ? rd_mux : 32'h00000000;
        end
    end

    assign rd_data         = rd_data_reg;
    assign point_out       = point_out_reg;
    assign failsafe_active = failsafe_reg;
    assign comm_lost       = comm_lost_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    out_follow_a:      assert property (!fs_live |=> point_out == $past(image_reg))
        else $error("outputs do not follow the image");
    kind_off_a:        assert property (fs_live && act_cfg_reg.kind == KIND_ALL_OFF
                                        |=> point_out == 4'h0)
        else $error("kind one did not turn all points off");
    pattern_drive_a:   assert property (fs_live && kind_pat |=> point_out == $past(act_cfg_reg.pattern))
        else $error("pattern not driven in pattern mode");
    hold_last_a:       assert property (fs_live && kind_hld |=> $stable(point_out))
        else $error("hold mode changed an output");
    pattern_gate_a:    assert property (fs_live && !kind_pat && act_cfg_reg.pattern != 4'h0
                                        && !kind_hld |=> point_out == 4'h0)
        else $error("pattern leaked outside pattern mode");
    commit_clear_a:    assert property (commit_reg && !wr_commit |=> !commit_reg)
        else $error("commit strobe did not clear itself");
    staged_only_a:     assert property (!commit_reg |=> $stable(act_cfg_reg))
        else $error("active settings changed without commit");
    commit_xfer_a:     assert property (commit_reg |=> act_cfg_reg.delay == $past(stg_delay_reg)
                                        && act_cfg_reg.kind == $past(stg_kind_reg)
                                        && act_cfg_reg.pattern == $past(stg_pattern_reg))
        else $error("commit did not transfer staged settings");
    image_crop_a:      assert property (wr_image |=> image_reg == $past(host_req.wdata[3:0]))
        else $error("image write not cropped to four bits");
    image_read_a:      assert property (host_req.rd && host_req.addr == OFS_OUT_IMAGE
                                        |=> rd_data[31:4] == 28'h0000000 && rd_data[3:0] == $past(image_reg))
        else $error("image read shows wrong value");
    zero_delay_a:      assert property (state_reg == ST_NORMAL && lost_live
                                        && act_cfg_reg.delay == 8'h00 |=> failsafe_active ##0 comm_lost)
        else $error("zero delay did not enter fail-safe at once");
    resume_a:          assert property (traffic |=> !failsafe_active && !comm_lost)
        else $error("host traffic did not end fail-safe");
    loss_enter_a:      assert property (state_reg == ST_LOST && dly_done && !traffic
                                        |=> failsafe_active)
        else $error("delay expiry did not enter fail-safe");

    enter_pattern_c:   cover property (state_reg == ST_LOST ##1 failsafe_active && kind_pat);
    enter_hold_c:      cover property (fs_live && kind_hld ##1 failsafe_active);
    resume_c:          cover property (failsafe_active ##1 traffic ##1 !failsafe_active);
    commit_c:          cover property (wr_commit ##1 commit_reg ##1 !commit_reg);
endmodule // fsdo_port

// *** verif/fsdo_host_model.sv ***
// host controller model: issues accesses on the port's register bus
// assumes the port never stalls and read data stand one cycle after rd
`timescale 1ns/1ps
module fsdo_host_model (
    input  wire logic                       clk,
    input  wire logic [fsdo_pkg::DATA_W-1:0] rd_data,
    output fsdo_pkg::fsdo_req_t              req
);
    import fsdo_pkg::*;

    // bus idle with no strobe before the first access
    initial begin
        req = '0;
    end

    // one write cycle; address and data turn to their inverse once released
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk);
        req.wr    <= 1'b0;
        req.addr  <= ~a;
        req.wdata <= ~d;
    endtask

    // one read cycle; data taken in the single cycle where they stand
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd   <= 1'b0;
        req.addr <= ~a;
        #1;
        d = rd_data;
    endtask

    // staged settings only count once the commit strobe is written
    task automatic commit();
        wr(OFS_COMMIT, 32'h0000_0001);
    endtask
endmodule // fsdo_host_model

// *** verif/tb_top.sv ***
// self-checking bench of the fail-safe discrete output port
// assumes a shortened tenth of ten clocks so the watchdog trips quickly
`timescale 1ns/1ps
module tb_top;
    import fsdo_pkg::*;

    localparam int unsigned TC = 10;

    logic                  clk;
    logic                  rstn;
    fsdo_req_t             host_req;
    logic [DATA_W-1:0]     rd_data;
    logic [NUM_POINTS-1:0] point_out;
    logic                  failsafe_active;
    logic                  comm_lost;
    int                    failures = 0;
    int                    n_tests = 0;
    int                    cyc = 0;
    int                    n;
    logic [31:0]           d;
    logic [3:0]            img;
    logic [3:0]            pat;
    logic [7:0]            ak;
    logic [7:0]            ad;
    logic [3:0]            ap;
    logic [7:0]            kinds [5] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h02};
    logic [7:0]            dels  [5] = '{8'h00, 8'h03, 8'h01, 8'h00, 8'hff};

    fsdo_port #(.TENTH_CYCLES(TC)) DUT (
        .clk             (clk),
        .rstn            (rstn),
        .host_req        (host_req),
        .rd_data         (rd_data),
        .point_out       (point_out),
        .failsafe_active (failsafe_active),
        .comm_lost       (comm_lost)
    );

    fsdo_host_model host (
        .clk     (clk),
        .rd_data (rd_data),
        .req     (host_req)
    );

    // free-running clock
    initial begin
        clk = 1'b0;
    end
    always #25 clk = ~clk;

    // cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 9000) begin
            failures++;
            finish_test();
        end
    end

    // compare and count
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic ticks(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // wait counted in tenths: one cycle early to two cycles late is on time
    function automatic logic [31:0] in_win(int got, int tenths);
        in_win = 32'(got >= tenths * int'(TC) - 1 && got <= tenths * int'(TC) + 2);
    endfunction

    // expected drive in fail-safe; unknown kinds behave as all off
    function automatic logic [3:0] fs_exp(logic [7:0] k, logic [3:0] p, logic [3:0] i);
        case (k)
            KIND_PATTERN: fs_exp = p;
            KIND_HOLD:    fs_exp = i;
            default:      fs_exp = 4'h0;
        endcase
    endfunction

    // main sequence
    initial begin
        rstn = 1'b0;
        d = $urandom(32'h6d69a47f);
        ak = RST_KIND;
        ad = RST_DELAY;
        ap = RST_PATTERN;
        img = RST_IMAGE;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        ticks(1);
        check("points after reset", 32'(point_out), 32'h0);
        host.rd(OFS_STATUS, d);
        check("status after reset", d >> 8, {12'h0, ap, ad, ak});
        $display("test reset done");

        // whole-image writes with random upper bits
        repeat (8) begin
            d = $urandom();
            host.wr(OFS_OUT_IMAGE, d);
            img = d[3:0];
            host.rd(OFS_OUT_IMAGE, d);
            check("image readback", d, 32'(img));
            ticks(1);
            check("points", 32'(point_out), 32'(img));
        end
        // single-point writes, every point once
        for (int p = 0; p < 4; p++) begin
            d = $urandom();
            host.wr(OFS_OUT_POINT, {23'h0, d[0], 8'(p)});
            img[p] = d[0];
            ticks(2);
            check("point write", 32'(point_out), 32'(img));
        end
        host.rd(8'h20, d);
        check("unmapped read", d, 32'h0);
        $display("test image done");

        // every kind; kinds 1 and 0 without entry delay, kinds 2 and 3 with
        for (int i = 0; i < 5; i++) begin
            host.wr(OFS_KIND_STAGE, {24'h0, kinds[i]});
            host.wr(OFS_DELAY_STAGE, {24'h0, dels[i]});
            d = $urandom();
            host.wr(OFS_PAT_STAGE, d);
            pat = d[3:0];
            d = $urandom();
            host.wr(OFS_PAT_POINT, {23'h0, d[8], 6'h0, d[1:0]});
            pat[d[1:0]] = d[8];
            host.rd(OFS_PAT_STAGE, d);
            check("staged pattern", d, 32'(pat));
            host.rd(OFS_STATUS, d);
            check("status before commit", d >> 8, {12'h0, ap, ad, ak});
            host.commit();
            ticks(3);
            ak = kinds[i];
            ad = dels[i];
            ap = pat;
            host.rd(OFS_COMMIT, d);
            check("commit clears", d, 32'h0);
            host.rd(OFS_STATUS, d);
            check("status after commit", d >> 8, {12'h0, ap, ad, ak});
            d = $urandom();
            host.wr(OFS_OUT_IMAGE, d);
            img = d[3:0];
            // host falls silent
            n = 0;
            while (comm_lost !== 1'b1 && n < 200) begin
                ticks(1);
                n++;
            end
            check("loss time", in_win(n, int'(WDOG_TENTHS)), 32'h1);
            if (dels[i] == 8'h00) begin
                check("immediate entry", 32'(failsafe_active), 32'h1);
            end else begin
                check("held during delay", 32'(point_out), 32'(img));
                n = 0;
                while (failsafe_active !== 1'b1 && n < 3000) begin
                    ticks(1);
                    n++;
                end
                check("entry delay", in_win(n, int'(dels[i])), 32'h1);
            end
            check("fail-safe drive", 32'(point_out), 32'(fs_exp(ak, ap, img)));
            host.rd(OFS_STATUS, d);
            check("status in fail-safe", 32'(d[1:0]), 32'h3);
            ticks(1);
            check("resume", {26'h0, failsafe_active, comm_lost, point_out}, {28'h0, img});
            $display("test kind %0d delay %0d done", kinds[i], dels[i]);
        end
        finish_test();
    end
endmodule // tb_top
